// file: core/cma_array_access.sv
// memory-mapped access to instruction and operand cache arrays
// Summary of operation
// - instruction tag read returns stored tag and valid, never compares
// - plain instruction tag write stores tag and valid; A must be zero
// - assoc instruction tag write compares; mmu on translates [31:10]
// - only a match on a valid entry updates valid; else silent no-op
// - instruction translation multiple hit raises exception, no write
// - top byte F1 selects instruction data array, entry from [12:5]
// - address bits [4:2] pick the longword within the line
// - instruction data write stores longword; read returns it
// - top byte F4 selects operand tag array, entry from [13:5]
// - address bit 3 selects associative or plain tag write
// - operand tag word: tag [28:10], dirty [1], valid [0]
// - operand tag read returns tag, dirty, valid, ignoring A
// - plain operand tag write to dirty valid line writes back first
// - assoc operand tag write compares; mmu on uses unified buffer
// - valid match sets flags; dirty line losing a flag is written back
// - miss or mismatch silent; data multiple hit raises exception
// - top byte F5 selects operand data array, entry from [13:5]
// - operand data read returns the selected longword
// - top byte F0 selects instruction tag array, entry from [12:5]
// - operand data write stores longword without setting dirty flag
`timescale 1ns/1ns
`include "cma_regs.svh"
module cma_array_access
   import cma_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   // cpu access port
   input  wire logic        i_req,
   input  wire logic        i_we,
   input  wire logic [31:0] i_addr,
   input  wire logic [31:0] i_wdata,
   output logic             o_ready,
   output logic             o_ack,
   output logic [31:0]      o_rdata,
   // translation control
   input  wire logic        i_mmu_enable,
   output logic             o_xlat_req,
   output logic             o_xlat_unified,
   output logic [21:0]      o_xlat_vaddr,
   input  wire logic        i_xlat_done,
   input  wire logic        i_xlat_hit,
   input  wire logic        i_xlat_multi,
   input  wire logic [18:0] i_xlat_ptag,
   // exceptions
   output logic             o_instr_translation_buffer_multi_exc,
   output logic             o_dtlb_multi_exc,
   // line write-back
   output logic             o_wb_valid,
   output logic [28:0]      o_wb_addr,
   output logic [31:0]      o_wb_data,
   output logic             o_wb_last,
   input  wire logic        i_wb_ready
);
   // arrays
   cma_mem_if #(.AW(8),  .DW(19)) ict_if ();
   cma_mem_if #(.AW(11), .DW(32)) icd_if ();
   cma_mem_if #(.AW(9),  .DW(19)) oct_if ();
   cma_mem_if #(.AW(12), .DW(32)) ocd_if ();

   cma_mem #(.AW(8),  .DW(19)) u_ic_tag  (.i_clk_sys(i_clk_sys), .port(ict_if));
   cma_mem #(.AW(11), .DW(32)) u_ic_data (.i_clk_sys(i_clk_sys), .port(icd_if));
   cma_mem #(.AW(9),  .DW(19)) u_oc_tag  (.i_clk_sys(i_clk_sys), .port(oct_if));
   cma_mem #(.AW(12), .DW(32)) u_oc_data (.i_clk_sys(i_clk_sys), .port(ocd_if));

   // state
   cma_state_t  state;
   cma_state_t  next_state;
   cma_array_t  sel;
   cma_array_t  next_sel;
   logic [31:0] addr;
   logic [31:0] next_addr;
   logic [31:0] wdata;
   logic [31:0] next_wdata;
   logic        we;
   logic        next_we;
   logic [18:0] old_tag;
   logic [18:0] next_old_tag;
   logic [2:0]  wb_cnt;
   logic [2:0]  next_wb_cnt;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic        instr_translation_buffer_exc;
   logic        next_instr_translation_buffer_exc;
   logic        dtlb_exc;
   logic        next_dtlb_exc;
   logic [255:0] ic_valid;
   logic [255:0] next_ic_valid;
   logic [511:0] oc_valid;
   logic [511:0] next_oc_valid;
   logic [511:0] oc_dirty;
   logic [511:0] next_oc_dirty;

   // decoded fields of the latched access
   logic [7:0]  ic_idx;
   logic [8:0]  oc_idx;
   logic [2:0]  lw;
   logic        assoc;
   logic [18:0] new_tag;
   logic        new_v;
   logic        new_u;
   logic        cur_v;
   logic        cur_u;
   logic        match_tag;
   logic        wb_needed;
   logic [18:0] look_tag;

   assign ic_idx  = addr[`CMA_IC_IDX_HI:`CMA_IDX_LO];
   assign oc_idx  = addr[`CMA_OC_IDX_HI:`CMA_IDX_LO];
   assign lw      = addr[`CMA_LW_HI:`CMA_LW_LO];
   assign assoc   = addr[`CMA_ASSOC_BIT];
   assign new_tag = wdata[`CMA_TAG_HI:`CMA_TAG_LO];
   assign new_u   = wdata[`CMA_DIRTY_BIT];
   assign new_v   = wdata[`CMA_VALID_BIT];
   assign cur_v   = (sel == CMA_IC_TAG) ? ic_valid[ic_idx] : oc_valid[oc_idx];
   assign cur_u   = (sel == CMA_OC_TAG) && oc_dirty[oc_idx];
   assign look_tag = (sel == CMA_IC_TAG) ? ict_if.rdata : oct_if.rdata;
   // dirty valid line whose flags get dropped must be flushed first
   assign wb_needed = cur_u && cur_v
                      && (!assoc || !new_u || !new_v);

   // array select from the top address byte
   function automatic cma_array_t decode(input logic [7:0] top);
      case (top)
         `CMA_SEL_IC_TAG:  decode = CMA_IC_TAG;
         `CMA_SEL_IC_DATA: decode = CMA_IC_DATA;
         `CMA_SEL_OC_TAG:  decode = CMA_OC_TAG;
         `CMA_SEL_OC_DATA: decode = CMA_OC_DATA;
         default:          decode = CMA_NONE;
      endcase
   endfunction : decode

   // handshake and translation outputs
   assign o_ready        = (state == CMA_IDLE);
   assign o_ack          = (state == CMA_DONE);
   assign o_rdata        = rdata;
   assign o_xlat_req     = (state == CMA_XLAT);
   assign o_xlat_unified = (sel == CMA_OC_TAG);
   assign o_xlat_vaddr   = wdata[`CMA_VA_HI:`CMA_TAG_LO];
   assign o_instr_translation_buffer_multi_exc = instr_translation_buffer_exc;
   assign o_dtlb_multi_exc = dtlb_exc;
   assign o_wb_valid     = (state == CMA_WB_SEND);
   assign o_wb_addr      = {old_tag, oc_idx[4:0], wb_cnt, 2'b00};
   assign o_wb_data      = ocd_if.rdata;
   assign o_wb_last      = (wb_cnt == `CMA_LW_LAST);

   // array ports, addressed from the latched access
   always_comb begin
      ict_if.addr  = ic_idx;
      ict_if.wdata = new_tag;
      ict_if.we    = (state == CMA_UPDATE) && (sel == CMA_IC_TAG) && !assoc;
      oct_if.addr  = oc_idx;
      oct_if.wdata = new_tag;
      oct_if.we    = (state == CMA_UPDATE) && (sel == CMA_OC_TAG) && !assoc;
      icd_if.addr  = {ic_idx, lw};
      icd_if.wdata = wdata;
      icd_if.we    = (state == CMA_ACCESS) && (sel == CMA_IC_DATA) && we;
      ocd_if.addr  = (state == CMA_WB_RD || state == CMA_WB_SEND) ?
                     {oc_idx, wb_cnt} : {oc_idx, lw};
      ocd_if.wdata = wdata;
      ocd_if.we    = (state == CMA_ACCESS) && (sel == CMA_OC_DATA) && we;
   end

   // tag compare against plain or translated tag
   always_comb begin
      match_tag = (old_tag == new_tag);
      if (i_mmu_enable) begin
         match_tag = (old_tag == i_xlat_ptag);
      end
   end

   // sequencer next values
   always_comb begin
      next_state    = state;
      next_sel      = sel;
      next_addr     = addr;
      next_wdata    = wdata;
      next_we       = we;
      next_old_tag  = old_tag;
      next_wb_cnt   = wb_cnt;
      next_rdata    = rdata;
      next_instr_translation_buffer_exc = 1'b0;
      next_dtlb_exc = 1'b0;
      next_ic_valid = ic_valid;
      next_oc_valid = oc_valid;
      next_oc_dirty = oc_dirty;
      case (state)
         CMA_IDLE: begin
            if (i_req) begin
               next_addr  = i_addr;
               next_wdata = i_wdata;
               next_we    = i_we;
               next_sel   = decode(i_addr[`CMA_SEL_HI:`CMA_SEL_LO]);
               next_state = CMA_ACCESS;
            end
         end
         CMA_ACCESS: begin
            // unmapped reads give zero; data writes finish here
            next_rdata = `CMA_RST_WORD;
            if (sel == CMA_NONE || (we && (sel == CMA_IC_DATA ||
                sel == CMA_OC_DATA))) begin
               next_state = CMA_DONE;
            end else begin
               next_state = CMA_LOOK;
            end
         end
         CMA_LOOK: begin
            next_old_tag = (sel == CMA_IC_TAG) ? ict_if.rdata : oct_if.rdata;
            next_wb_cnt  = 3'h0;
            if (!we) begin
               next_state = CMA_DONE;
               case (sel)
                  CMA_IC_TAG:  next_rdata = {3'h0, ict_if.rdata, 8'h00,
                                             1'b0, cur_v};
                  CMA_OC_TAG:  next_rdata = {3'h0, oct_if.rdata, 8'h00,
                                             cur_u, cur_v};
                  CMA_IC_DATA: next_rdata = icd_if.rdata;
                  default:     next_rdata = ocd_if.rdata;
               endcase
            end else if (assoc && i_mmu_enable) begin
               next_state = CMA_XLAT;
            end else if (assoc && (look_tag != new_tag || !cur_v)) begin
               next_state = CMA_DONE;
            end else if (wb_needed) begin
               next_state = CMA_WB_RD;
            end else begin
               next_state = CMA_UPDATE;
            end
         end
         CMA_XLAT: begin
            if (i_xlat_done) begin
               if (i_xlat_multi) begin
                  next_instr_translation_buffer_exc = (sel == CMA_IC_TAG);
                  next_dtlb_exc = (sel == CMA_OC_TAG);
                  next_state    = CMA_DONE;
               end else if (!i_xlat_hit || !match_tag || !cur_v) begin
                  next_state = CMA_DONE;
               end else if (wb_needed) begin
                  next_state = CMA_WB_RD;
               end else begin
                  next_state = CMA_UPDATE;
               end
            end
         end
         CMA_WB_RD: begin
            next_state = CMA_WB_SEND;
         end
         CMA_WB_SEND: begin
            if (i_wb_ready) begin
               next_wb_cnt = wb_cnt + 3'h1;
               next_state  = o_wb_last ? CMA_UPDATE : CMA_WB_RD;
            end
         end
         CMA_UPDATE: begin
            next_state = CMA_DONE;
            if (!assoc || i_mmu_enable || (match_tag && cur_v)) begin
               if (sel == CMA_IC_TAG) begin
                  next_ic_valid[ic_idx] = new_v;
               end else begin
                  next_oc_valid[oc_idx] = new_v;
                  next_oc_dirty[oc_idx] = new_u;
               end
            end
         end
         CMA_DONE: begin
            next_state = CMA_IDLE;
         end
         default: begin
            next_state = CMA_IDLE;
         end
      endcase
   end

   // assoc writes reach update only after a match on a valid entry, so a
   // flush never precedes a silent no-op
   // sequencer registers
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state    <= CMA_IDLE;
         sel      <= CMA_NONE;
         addr     <= `CMA_RST_WORD;
         wdata    <= `CMA_RST_WORD;
         we       <= `CMA_RST_FLAGS;
         old_tag  <= 19'h0_0000;
         wb_cnt   <= 3'h0;
         rdata    <= `CMA_RST_WORD;
         instr_translation_buffer_exc <= `CMA_RST_FLAGS;
         dtlb_exc <= `CMA_RST_FLAGS;
         ic_valid <= '0;
         oc_valid <= '0;
         oc_dirty <= '0;
      end else begin
         state    <= next_state;
         sel      <= next_sel;
         addr     <= next_addr;
         wdata    <= next_wdata;
         we       <= next_we;
         old_tag  <= next_old_tag;
         wb_cnt   <= next_wb_cnt;
         rdata    <= next_rdata;
         instr_translation_buffer_exc <= next_instr_translation_buffer_exc;
         dtlb_exc <= next_dtlb_exc;
         ic_valid <= next_ic_valid;
         oc_valid <= next_oc_valid;
         oc_dirty <= next_oc_dirty;
      end
   end
endmodule : cma_array_access

// file: core/cma_mem.sv
// single-port array memory with registered read data
`timescale 1ns/1ns
module cma_mem #(
   parameter int AW = 8,
   parameter int DW = 32
) (
   // clock
   input  wire logic i_clk_sys,
   // access port
   cma_mem_if.mem    port
);
   logic [DW-1:0] store [0:(1<<AW)-1];

   // read before write, read returns old contents one cycle later
   always_ff @(posedge i_clk_sys) begin
      if (port.we) begin
         store[port.addr] <= port.wdata;
      end
      port.rdata <= store[port.addr];
   end
endmodule : cma_mem

// file: core/cma_mem_if.sv
// port bundle between the access logic and one array memory
`timescale 1ns/1ns
interface cma_mem_if #(parameter int AW = 8, parameter int DW = 32);
   logic          we;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   modport user (output we, output addr, output wdata, input rdata);
   modport mem  (input we, input addr, input wdata, output rdata);
endinterface : cma_mem_if

// file: core/cma_pkg.sv
// types shared by the cache array access logic
package cma_pkg;
   typedef enum logic [2:0] {
      CMA_NONE, CMA_IC_TAG, CMA_IC_DATA, CMA_OC_TAG, CMA_OC_DATA
   } cma_array_t;
   typedef enum logic [3:0] {
      CMA_IDLE, CMA_ACCESS, CMA_LOOK, CMA_XLAT, CMA_WB_RD, CMA_WB_SEND,
      CMA_UPDATE, CMA_DONE
   } cma_state_t;
endpackage : cma_pkg

// file: core/cma_regs.svh
// address decode, field positions and reset values for the cache array port
`ifndef CMA_REGS_SVH
`define CMA_REGS_SVH
`define CMA_SEL_HI       31
`define CMA_SEL_LO       24
`define CMA_SEL_IC_TAG   8'hF0
`define CMA_SEL_IC_DATA  8'hF1
`define CMA_SEL_OC_TAG   8'hF4
`define CMA_SEL_OC_DATA  8'hF5
`define CMA_IC_IDX_HI    12
`define CMA_OC_IDX_HI    13
`define CMA_IDX_LO       5
`define CMA_LW_HI        4
`define CMA_LW_LO        2
`define CMA_ASSOC_BIT    3
`define CMA_TAG_HI       28
`define CMA_TAG_LO       10
`define CMA_VA_HI        31
`define CMA_DIRTY_BIT    1
`define CMA_VALID_BIT    0
`define CMA_LW_LAST      3'h7
`define CMA_RST_WORD     32'h0000_0000
`define CMA_RST_FLAGS    1'h0
`endif

// file: verif/cma_array_access_assertions.sv
// concurrent checks on the cache array access port
`timescale 1ns/1ns
`include "cma_regs.svh"
module cma_access_chk (
   // watched ports
   input wire logic        i_clk_sys,
   input wire logic        i_rst,
   input wire logic        i_req,
   input wire logic        i_we,
   input wire logic [31:0] i_addr,
   input wire logic        o_ready,
   input wire logic        o_ack,
   input wire logic [31:0] o_rdata,
   input wire logic        o_xlat_req,
   input wire logic        i_xlat_done,
   input wire logic        i_xlat_multi,
   input wire logic        o_instr_translation_buffer_multi_exc,
   input wire logic        o_dtlb_multi_exc,
   input wire logic        o_wb_valid,
   input wire logic [28:0] o_wb_addr,
   input wire logic        i_wb_ready
);
   logic take, data_sel, tag_rd, next_tag_rd;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // note whether the access in flight reads a tag array
   assign take = i_req && o_ready;
   assign data_sel = i_addr[31:24] == `CMA_SEL_IC_DATA
                     || i_addr[31:24] == `CMA_SEL_OC_DATA;
   always_comb begin
      next_tag_rd = tag_rd;
      if (take)
         next_tag_rd = !i_we && (i_addr[31:24] == `CMA_SEL_IC_TAG
                       || i_addr[31:24] == `CMA_SEL_OC_TAG);
   end
   always_ff @(posedge i_clk_sys or posedge i_rst)
      if (i_rst) tag_rd <= 1'b0;
      else tag_rd <= next_tag_rd;
   sequence s_data_read; take && !i_we && data_sel; endsequence
   sequence s_multi; o_xlat_req && i_xlat_done && i_xlat_multi; endsequence
   chk_read_lat: assert property (s_data_read |-> ##3 o_ack)
      else $error("data read not answered in three cycles");
   chk_write_lat: assert property (
      take && i_we && data_sel |-> ##2 o_ack)
      else $error("data write not answered in two cycles");
   chk_ack_pulse: assert property (o_ack |=> !o_ack && o_ready)
      else $error("ack longer than one cycle or port not free");
   chk_busy_take: assert property (take |=> !o_ready [*2])
      else $error("port free right after a take");
   chk_multi_exc: assert property (
      s_multi |=> o_ack && (o_instr_translation_buffer_multi_exc || o_dtlb_multi_exc))
      else $error("multiple hit not reported with ack");
   chk_exc_ack: assert property (
      o_instr_translation_buffer_multi_exc || o_dtlb_multi_exc |-> o_ack)
      else $error("exception pulse without ack");
   chk_wb_hold: assert property (
      o_wb_valid && !i_wb_ready |=> o_wb_valid && $stable(o_wb_addr))
      else $error("write-back word dropped while stalled");
   chk_tag_zero: assert property (
      o_ack && tag_rd |-> o_rdata[31:29] == 3'h0 && o_rdata[9:2] == 8'h00)
      else $error("unused tag read bits not zero");
   chk_xlat_wait: assert property (
      o_xlat_req && !i_xlat_done |=> o_xlat_req)
      else $error("translation request withdrawn early");
endmodule : cma_access_chk
bind cma_array_access cma_access_chk u_chk (
   .i_clk_sys, .i_rst, .i_req, .i_we, .i_addr, .o_ready, .o_ack, .o_rdata,
   .o_xlat_req, .i_xlat_done, .i_xlat_multi, .o_instr_translation_buffer_multi_exc,
   .o_dtlb_multi_exc, .o_wb_valid, .o_wb_addr, .i_wb_ready);

// file: verif/cma_far_model.sv
// far side model: translation buffer answers and write-back sink
`timescale 1ns/1ns
module cma_far_model (
   // clock
   input  wire logic        i_clk_sys,
   // from the block and the scenario
   input  wire logic        i_xlat_req,
   input  wire logic        i_hit,
   input  wire logic        i_multi,
   input  wire logic [18:0] i_ptag,
   input  wire logic        i_stall,
   // answers
   output logic             o_done,
   output logic             o_hit,
   output logic             o_multi,
   output logic [18:0]      o_ptag,
   output logic             o_wb_ready
);
   logic [1:0] cnt = 2'h0;
   logic       tog = 1'b0;
   // count cycles of a pending lookup; flip the stall pattern
   always_ff @(posedge i_clk_sys) begin
      cnt <= i_xlat_req ? cnt + 2'h1 : 2'h0;
      tog <= ~tog;
   end
   // answer late in a lookup; flags inverted outside the answer cycle
   assign o_done = i_xlat_req && cnt == 2'h2;
   assign o_hit = o_done ? i_hit : ~i_hit;
   assign o_multi = o_done ? i_multi : ~i_multi;
   assign o_ptag = i_ptag;
   assign o_wb_ready = ~i_stall | tog;
endmodule : cma_far_model

// file: verif/tb_top.sv
// self-checking bench for the cache array access block
`timescale 1ns/1ns
module tb_top;
   logic        clk = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0;
   logic        mmu = 1'b0, hit = 1'b0, multi = 1'b0, stall = 1'b0;
   logic [18:0] ptag = 19'h7_FFFF;
   logic [31:0] addr = 32'h0000_0000, wdata = 32'h0000_0000;
   logic        ready, ack, xreq, xuni, xdone, xhit, xmul, iexc, dexc;
   logic        wbv, wbr, wbl, ei, ed, xu;
   logic [31:0] rdata, wbd, rd;
   logic [28:0] wba;
   logic [21:0] xva, xv;
   logic [18:0] xpt;
   logic [28:0] wa[$];
   logic [31:0] wd[$];
   logic        wl[$];
   int          mismatches = 0, checked = 0, cyc = 0;
   always #4 clk = ~clk;
   cma_array_access uut (.i_clk_sys(clk), .i_rst(rst), .i_req(req),
      .i_we(we), .i_addr(addr), .i_wdata(wdata), .o_ready(ready),
      .o_ack(ack), .o_rdata(rdata), .i_mmu_enable(mmu), .o_xlat_req(xreq),
      .o_xlat_unified(xuni), .o_xlat_vaddr(xva), .i_xlat_done(xdone),
      .i_xlat_hit(xhit), .i_xlat_multi(xmul), .i_xlat_ptag(xpt),
      .o_instr_translation_buffer_multi_exc(iexc), .o_dtlb_multi_exc(dexc), .o_wb_valid(wbv),
      .o_wb_addr(wba), .o_wb_data(wbd), .o_wb_last(wbl), .i_wb_ready(wbr));
   cma_far_model far (.i_clk_sys(clk), .i_xlat_req(xreq), .i_hit(hit),
      .i_multi(multi), .i_ptag(ptag), .i_stall(stall), .o_done(xdone),
      .o_hit(xhit), .o_multi(xmul), .o_ptag(xpt), .o_wb_ready(wbr));
   // collect write-back words and translation requests
   always @(negedge clk) begin
      if (wbv && wbr) begin
         wa.push_back(wba);
         wd.push_back(wbd);
         wl.push_back(wbl);
      end
      if (xreq) begin
         xv = xva;
         xu = xuni;
      end
   end
   // cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         mismatches++;
         conclude();
      end
   end
   task conclude;
      if (mismatches == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s %h / %h", $time, what, got, exp);
      end
   endtask : chk
   // one privileged longword access, ack awaited under a bound
   task acc(input logic w, input logic [31:0] a, d);
      int n;
      n = 0;
      @(posedge clk);
      req <= 1'b1; we <= w; addr <= a; wdata <= d;
      @(posedge clk);
      req <= 1'b0;
      do begin @(negedge clk); n++; end while (ack !== 1'b1 && n < 300);
      chk({31'h0, ack}, 32'h0000_0001, "ack");
      rd = rdata; ei = iexc; ed = dexc;
   endtask : acc
   task cfg(input logic m, h, x, s);
      @(posedge clk);
      mmu <= m; hit <= h; multi <= x; stall <= s;
   endtask : cfg
   // eight write-back words of operand line 0x1ff
   task wbchk;
      logic [31:0] e;
      chk(wa.size(), 32'h0000_0008, "wb count");
      chk({3'h0, wa[0]}, {3'h0, 19'h4_8D15, 10'h3E0}, "wb addr");
      chk({31'h0, wl[0]}, 32'h0000_0000, "wb first");
      chk({31'h0, wl[7]}, 32'h0000_0001, "wb last");
      for (int i = 0; i < 8; i++) begin
         e = 32'hA5A5_0000 ^ (32'hF500_3FE0 + 32'(4*i));
         chk(wd[i], e, "wb");
      end
      wa.delete(); wd.delete(); wl.delete();
   endtask : wbchk
   task t_data;
      logic [31:0] b, e;
      for (int k = 0; k < 2; k++) begin
         b = k ? 32'hF500_3FE0 : 32'hF100_1FE0;
         for (int i = 0; i < 8; i++)
            acc(1'b1, b + (k ? 32'h0000_4000 : 32'h0000_2000) + 32'(4*i),
                32'hA5A5_0000 ^ (b + 32'(4*i)));
         for (int i = 0; i < 8; i++) begin
            acc(1'b0, b + 32'(4*i), 32'h0000_0000);
            e = 32'hA5A5_0000 ^ (b + 32'(4*i));
            chk(rd, e, "data");
         end
      end
   endtask : t_data
   task t_itag;
      acc(1'b1, 32'hF000_0020, 32'hFFFF_FC03);
      acc(1'b0, 32'hF000_0028, 32'h0000_0000);
      chk(rd, 32'h1FFF_FC01, "itag read");
      acc(1'b1, 32'hF000_0028, 32'h0000_0400);
      acc(1'b0, 32'hF000_0020, 32'h0000_0000);
      chk(rd, 32'h1FFF_FC01, "itag mismatch");
      acc(1'b1, 32'hF000_0028, 32'hFFFF_FC00);
      acc(1'b0, 32'hF000_0020, 32'h0000_0000);
      chk(rd, 32'h1FFF_FC00, "itag match");
      cfg(1'b1, 1'b0, 1'b0, 1'b0);
      acc(1'b1, 32'hF000_0020, 32'hFFFF_FC03);
      acc(1'b1, 32'hF000_0028, 32'h0000_0000);
      acc(1'b0, 32'hF000_0020, 32'h0000_0000);
      chk(rd, 32'h1FFF_FC01, "itag xlat miss");
      cfg(1'b1, 1'b1, 1'b0, 1'b0);
      acc(1'b1, 32'hF000_0028, 32'h1234_5400);
      chk({10'h0, xv}, 32'h0004_8D15, "xlat vaddr");
      chk({31'h0, xu}, 32'h0000_0000, "xlat select");
      acc(1'b0, 32'hF000_0020, 32'h0000_0000);
      chk(rd, 32'h1FFF_FC00, "itag xlat hit");
      acc(1'b1, 32'hF000_0020, 32'hFFFF_FC03);
      cfg(1'b1, 1'b1, 1'b1, 1'b0);
      acc(1'b1, 32'hF000_0028, 32'h0000_0000);
      chk({31'h0, ei}, 32'h0000_0001, "instr_translation_buffer multi");
      acc(1'b0, 32'hF000_0020, 32'h0000_0000);
      chk(rd, 32'h1FFF_FC01, "itag kept");
      acc(1'b0, 32'hF200_0020, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "unmapped read");
   endtask : t_itag
   task t_otag;
      cfg(1'b0, 1'b0, 1'b0, 1'b1);
      acc(1'b1, 32'hF400_3FE0, 32'h1234_5403);
      acc(1'b0, 32'hF400_3FE8, 32'h0000_0000);
      chk(rd, 32'h1234_5403, "otag read");
      wa.delete(); wd.delete(); wl.delete();
      acc(1'b1, 32'hF400_3FE0, 32'h1234_5403);
      wbchk();
      acc(1'b1, 32'hF400_3FE8, 32'h1234_5400);
      wbchk();
      acc(1'b1, 32'hF500_3FE0, 32'h0000_0000);
      acc(1'b0, 32'hF400_3FE0, 32'h0000_0000);
      chk(rd, 32'h1234_5400, "otag flags");
      cfg(1'b1, 1'b0, 1'b1, 1'b0);
      acc(1'b1, 32'hF400_3FE8, 32'h0000_0000);
      chk({31'h0, ed}, 32'h0000_0001, "dtlb multi");
      chk({31'h0, xu}, 32'h0000_0001, "xlat select");
   endtask : t_otag
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_data();
      t_itag();
      t_otag();
      conclude();
   end
endmodule : tb_top
